// ### sdir_cfg.svh
/*
 * Constants of the safety diagnostic and interrupt report block: serial
 * command codes, field positions, reset values and pulse timing.
 * Assumes it is included by bare name, after the clock rate is fixed.
 */
`ifndef SDIR_CFG_SVH
`define SDIR_CFG_SVH

// ****************************************
// Serial commands
// ****************************************
`define SDIR_CMD_READ_DIAG 16'h5c00
`define SDIR_CMD_READ_INTA 16'h6200
`define SDIR_CMD_READ_INTERRUPT_OUT_N 16'h6400
`define SDIR_CMD_INT_REQ 16'h6600
`define SDIR_CMD_INIT_DONE 16'h6800
`define SDIR_OP_WR_MASK 8'hc2
`define SDIR_OP_WR_BEHAV 8'hc4

// ****************************************
// Frame counting
// ****************************************
`define SDIR_RX_LAST 5'h0f
`define SDIR_RX_OVER 5'h10
`define SDIR_RX_SAT 5'h11

// ****************************************
// Fields and reset values
// ****************************************
`define SDIR_RST_ERR_RESET 3'h1
`define SDIR_RST_ERR_MAX 3'h6
`define SDIR_MASK_RESET 8'h00
`define SDIR_BEHAV_RESET 8'h00
`define SDIR_BEHAV_LONG 0
`define SDIR_BEHAV_OFF 1
`define SDIR_MSK_CHG 0
`define SDIR_MSK_WAKE 1
`define SDIR_MSK_TWARN 2
`define SDIR_MSK_ILIM 3
`define SDIR_MSK_TSD 4
`define SDIR_MSK_ILIM_OFF 5
`define SDIR_MSK_SPI 6
`define SDIR_PEND_MAX 4'hf

// ****************************************
// Timing
// ****************************************
`define SDIR_CLK_MHZ 200
`define SDIR_PULSE_SHORT_US 25
`define SDIR_PULSE_LONG_US 100

`endif

// ### sdir_host_model.sv
/*
 * Host serial master model for the diagnostic report block.
 * Assumes the bench calls frame() and takes each reply when done_out pulses.
 */
`timescale 1ns/100ps
`default_nettype none

module sdir_host_model (
   // Link to the device
   output logic link_clk_out,
   output logic serial_select_n_out,
   output logic mosi_out,
   input wire logic miso_in,
   input wire logic miso_oe_in,
   // Reply to the bench
   output logic [15:0] reply_out,
   output logic done_out
);
   initial begin
      link_clk_out = 1'b0;
      serial_select_n_out = 1'b1;
      mosi_out = 1'b0;
      reply_out = 16'h0000;
      done_out = 1'b0;
   end

   // ****************************************
   // One frame of n link clocks, 30 ns period
   // ****************************************
   // Link clock stands low outside frames; released lines show no old value
   task automatic frame(input logic [15:0] w, input int n);
      logic [15:0] r;
      r = 16'h0000;
      serial_select_n_out = 1'b0;
      #23.3;
      for (int i = 0; i < n; i++) begin
         link_clk_out = 1'b1;
         mosi_out = (i < 16) ? w[15 - i] : ~mosi_out;
         #15;
         link_clk_out = 1'b0;
         r = {r[14:0], miso_oe_in ? miso_in : ~r[0]};
         #15;
      end
      serial_select_n_out = 1'b1;
      mosi_out = ~mosi_out;
      reply_out = r;
      done_out = 1'b1;
      #5;
      done_out = 1'b0;
      // Gap lets the device evaluate the frame before the next one
      #100;
   endtask
endmodule // sdir_host_model

`default_nettype wire

// ### sdir_pkg.sv
/*
 * Types of the safety diagnostic and interrupt report block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package sdir_pkg;

   typedef enum {SDIR_IDLE, SDIR_PULSE} sdir_pulse_e;

   typedef struct packed {
      logic io45;
      logic io23;
      logic io1;
      logic io01;
   } sdir_fail_s;

   typedef struct packed {
      logic ilim_off;
      logic tsd;
      logic ilim;
      logic twarn;
   } sdir_reg_evt_s;

   typedef logic [15:0] sdir_word_t;

endpackage

`default_nettype wire

// ### sdir_report.sv
/*
 * Diagnostic read-back word and interrupt pulse logic, with its serial
 * slave. Assumes a 200 MHz system clock, a host serial clock that only runs
 * while serial_select_n_in is low, and event inputs from system-clock logic.
 */
// Overview of operation
// RULE1: A fixed 16-bit read command returns group flags high, diagnostics low.
// RULE2: Reset-error counter in bits 7..5 ranges 0..6, forced to 1 at reset.
// RULE3: Bit 3 flags pair 4/5 protocol error; cleared by reset or read.
// RULE4: Bit 2 flags pair 2/3 handshake error; cleared by reset or read.
// RULE5: Bit 1 flags resistor-string monitor failure; only reset clears it.
// RULE6: Bit 0 flags pair 0/1 protocol error; cleared by reset or read.
// RULE7: An unmasked interrupt condition drives a low pulse on interrupt_out_n.
// RULE8: Pulse behaviour and duration are set only during initialisation.
// RULE9: Mask settings stop selected sources from producing a pulse.
// RULE10: A level change on any of the six inputs is an interrupt event.
// RULE11: Each input's wake-up condition is its own interrupt event.
// RULE12: Thermal warning, current limit and shutdown flags are sources.
// RULE13: Expiry of maximum current-limit time is an interrupt event.
// RULE14: Buck or boost running state is reported as status.
// RULE15: Host gives exactly sixteen clocks per frame, else clock error.
// RULE16: Invalid accesses, bad writes and unknown commands are sources.
// RULE17: A host interrupt request command yields one pulse.
// RULE18: One pulse per new unmasked event; events during a pulse wait. Code: new events in one cycle share one pulse.
`timescale 1ns/100ps
`include "sdir_cfg.svh"
`default_nettype none

module sdir_report #(
   parameter int unsigned PULSE_SHORT_CYC = `SDIR_PULSE_SHORT_US * `SDIR_CLK_MHZ,
   parameter int unsigned PULSE_LONG_CYC = `SDIR_PULSE_LONG_US * `SDIR_CLK_MHZ
) (
   // System clock and reset
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   // Serial link from the host
   input wire logic link_clk_in,
   input wire logic serial_select_n_in,
   input wire logic mosi_in,
   output logic miso_out,
   output logic miso_oe_out,
   // Event sources
   input wire logic [7:0] global_flags_in,
   input wire sdir_pkg::sdir_fail_s fail_evt_in,
   input wire logic rst_err_inc_in,
   input wire logic rst_err_dec_in,
   input wire logic [5:0] io_level_in,
   input wire logic [5:0] io_wake_in,
   input wire sdir_pkg::sdir_reg_evt_s reg_evt_in,
   input wire logic buck_boost_state_in,
   // Interrupt and phase
   output logic interrupt_out_n,
   output logic init_phase_out
);

   function automatic sdir_pkg::sdir_word_t sdir_sticky(input sdir_pkg::sdir_word_t q,
      input sdir_pkg::sdir_word_t set, input sdir_pkg::sdir_word_t clr);
      // Set wins over a clear in the same cycle
      return (q & ~clr) | set;
   endfunction

   // ****************************************
   // Link clock domain
   // ****************************************
   wire logic link_clr = serial_select_n_in | ~resetn_in;
   logic [4:0] rx_cnt_q;
   logic [15:0] rx_sh_q;
   logic [15:0] rx_word_q;
   logic done_tgl_q;
   logic ovr_tgl_q;
   logic [3:0] tx_cnt_q;
   logic miso_q;
   logic miso_oe_q;
   sdir_pkg::sdir_word_t snap_q;

   // Host drives on rising edge, we sample on falling
   always_ff @(negedge link_clk_in or posedge link_clr) begin
      if (link_clr) begin
         rx_cnt_q <= 5'h00;
         rx_sh_q <= 16'h0000;
      end else begin
         rx_sh_q <= {rx_sh_q[14:0], mosi_in};
         if (rx_cnt_q != `SDIR_RX_SAT) begin
            rx_cnt_q <= rx_cnt_q + 5'h01;
         end
      end
   end

   // Word and toggles survive deselect so the system side can read them
   always_ff @(negedge link_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_word_q <= 16'h0000;
         done_tgl_q <= 1'b0;
         ovr_tgl_q <= 1'b0;
      end else begin
         if (rx_cnt_q == `SDIR_RX_LAST) begin
            rx_word_q <= {rx_sh_q[14:0], mosi_in};
            done_tgl_q <= ~done_tgl_q;
         end
         if (rx_cnt_q == `SDIR_RX_OVER) begin
            ovr_tgl_q <= ~ovr_tgl_q; // RULE15
         end
      end
   end

   // Snapshot is written only between frames, so it is static here
   always_ff @(posedge link_clk_in or posedge link_clr) begin
      if (link_clr) begin
         tx_cnt_q <= 4'h0;
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_oe_q <= 1'b1;
         miso_q <= snap_q[~tx_cnt_q];
         tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end

   assign miso_out = miso_q;
   assign miso_oe_out = miso_oe_q;

   // ****************************************
   // Synchronisers
   // ****************************************
   logic [3:0] cs_sync_q;
   logic [2:0] done_sync_q;
   logic [2:0] ovr_sync_q;
   logic [5:0] io_s1_q;
   logic [5:0] io_s2_q;
   logic [5:0] io_s3_q;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cs_sync_q <= 4'hf;
         done_sync_q <= 3'h0;
         ovr_sync_q <= 3'h0;
         io_s1_q <= 6'h00;
         io_s2_q <= 6'h00;
         io_s3_q <= 6'h00;
      end else if (clk_en_in) begin
         cs_sync_q <= {cs_sync_q[2:0], serial_select_n_in};
         done_sync_q <= {done_sync_q[1:0], done_tgl_q};
         ovr_sync_q <= {ovr_sync_q[1:0], ovr_tgl_q};
         io_s1_q <= io_level_in;
         io_s2_q <= io_s1_q;
         io_s3_q <= io_s2_q;
      end
   end

   // ****************************************
   // Frame tracking and command decode
   // ****************************************
   wire logic frame_start = ~cs_sync_q[2] & cs_sync_q[3];
   wire logic frame_end = cs_sync_q[2] & ~cs_sync_q[3];
   wire logic done_edge = done_sync_q[1] ^ done_sync_q[2];
   wire logic ovr_edge = ovr_sync_q[1] ^ ovr_sync_q[2];
   logic done_seen_q;
   logic ovr_seen_q;
   logic init_q;
   logic [7:0] mask_q;
   logic [7:0] behav_q;

   wire logic good = frame_end & done_seen_q & ~ovr_seen_q;
   wire logic cmd_rd_diag = good & (rx_word_q == `SDIR_CMD_READ_DIAG); // RULE1
   wire logic cmd_rd_a = good & (rx_word_q == `SDIR_CMD_READ_INTA);
   wire logic cmd_rd_b = good & (rx_word_q == `SDIR_CMD_READ_INTERRUPT_OUT_N);
   wire logic cmd_int_req = good & (rx_word_q == `SDIR_CMD_INT_REQ); // RULE17
   wire logic cmd_init_done = good & (rx_word_q == `SDIR_CMD_INIT_DONE);
   wire logic cmd_wr_mask = good & (rx_word_q[15:8] == `SDIR_OP_WR_MASK);
   wire logic cmd_wr_behav = good & (rx_word_q[15:8] == `SDIR_OP_WR_BEHAV);
   wire logic cmd_known = cmd_rd_diag | cmd_rd_a | cmd_rd_b | cmd_int_req | cmd_init_done
      | cmd_wr_mask | cmd_wr_behav;
   wire logic spi_clk_evt = frame_end & ~good; // RULE15
   wire logic spi_req_evt = (good & ~cmd_known)
      | ((cmd_wr_mask | cmd_wr_behav) & ~init_q); // RULE16

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         done_seen_q <= 1'b0;
         ovr_seen_q <= 1'b0;
      end else if (clk_en_in) begin
         done_seen_q <= done_edge | (done_seen_q & ~frame_start);
         ovr_seen_q <= ovr_edge | (ovr_seen_q & ~frame_start);
      end
   end

   // Settings accepted only while initialising
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         init_q <= 1'b1;
         mask_q <= `SDIR_MASK_RESET;
         behav_q <= `SDIR_BEHAV_RESET;
      end else if (clk_en_in) begin
         if (cmd_init_done) begin
            init_q <= 1'b0;
         end
         if (cmd_wr_mask & init_q) begin
            mask_q <= rx_word_q[7:0]; // RULE9
         end
         if (cmd_wr_behav & init_q) begin
            behav_q <= rx_word_q[7:0]; // RULE8
         end
      end
   end

   assign init_phase_out = init_q;

   // ****************************************
   // Diagnostic word and event flags
   // ****************************************
   logic [2:0] rst_err_q;
   sdir_pkg::sdir_fail_s fail_q;
   sdir_pkg::sdir_word_t stat_a_q;
   logic [2:0] stat_b_q;

   wire logic rst_up = rst_err_inc_in & ~rst_err_dec_in & (rst_err_q != `SDIR_RST_ERR_MAX);
   wire logic rst_dn = rst_err_dec_in & ~rst_err_inc_in & (rst_err_q != 3'h0);
   wire logic [3:0] fail_clr = {cmd_rd_diag, cmd_rd_diag, 1'b0, cmd_rd_diag}; // RULE3 RULE4 RULE5 RULE6
   wire logic [5:0] io_chg = io_s2_q ^ io_s3_q; // RULE10
   wire sdir_pkg::sdir_word_t set_a = {reg_evt_in, io_wake_in, io_chg}; // RULE11 RULE12 RULE13
   wire logic [2:0] set_b = {cmd_int_req, spi_req_evt, spi_clk_evt};
   wire sdir_pkg::sdir_word_t en_a = {~mask_q[`SDIR_MSK_ILIM_OFF], ~mask_q[`SDIR_MSK_TSD],
      ~mask_q[`SDIR_MSK_ILIM], ~mask_q[`SDIR_MSK_TWARN], {6{~mask_q[`SDIR_MSK_WAKE]}},
      {6{~mask_q[`SDIR_MSK_CHG]}}};
   wire logic [2:0] en_b = {1'b1, {2{~mask_q[`SDIR_MSK_SPI]}}};
   wire logic any_new = (|(set_a & ~stat_a_q & en_a)) | (|(set_b & ~stat_b_q & en_b)); // RULE9
   wire logic pulse_req = any_new & ~behav_q[`SDIR_BEHAV_OFF]; // RULE18
   wire sdir_pkg::sdir_word_t diag_word = {global_flags_in, rst_err_q, 1'b0, fail_q}; // RULE1

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_err_q <= `SDIR_RST_ERR_RESET; // RULE2
         fail_q <= '0;
         stat_a_q <= 16'h0000;
         stat_b_q <= 3'h0;
      end else if (clk_en_in) begin
         rst_err_q <= rst_err_q + {2'h0, rst_up} - {2'h0, rst_dn}; // RULE2
         fail_q <= 4'(sdir_sticky({12'h000, fail_q}, {12'h000, fail_evt_in},
            {12'h000, fail_clr})); // RULE3 RULE4 RULE5 RULE6
         stat_a_q <= sdir_sticky(stat_a_q, set_a, {16{cmd_rd_a}});
         stat_b_q <= 3'(sdir_sticky({13'h0000, stat_b_q}, {13'h0000, set_b},
            {13'h0000, {3{cmd_rd_b}}}));
      end
   end

   // Answer goes out in the frame after the command
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         snap_q <= 16'h0000;
      end else if (clk_en_in & good) begin
         if (cmd_rd_diag) begin
            snap_q <= diag_word; // RULE1
         end else if (cmd_rd_a) begin
            snap_q <= stat_a_q;
         end else if (cmd_rd_b) begin
            snap_q <= {buck_boost_state_in, 12'h000, stat_b_q}; // RULE14
         end else begin
            snap_q <= {global_flags_in, 8'h00};
         end
      end
   end

   // ****************************************
   // Interrupt pulse
   // ****************************************
   sdir_pkg::sdir_pulse_e state_q;
   logic [3:0] pend_q;
   logic [15:0] cnt_q;
   logic [15:0] len_q;
   logic int_n_q;

   wire logic pend_inc = pulse_req & (pend_q != `SDIR_PEND_MAX);
   wire logic pulse_start = (state_q == sdir_pkg::SDIR_IDLE) & (pend_q != 4'h0);
   wire logic pulse_last = (state_q == sdir_pkg::SDIR_PULSE) & (cnt_q == len_q - 16'h0001);
   wire logic [15:0] len_sel = behav_q[`SDIR_BEHAV_LONG] ? 16'(PULSE_LONG_CYC)
      : 16'(PULSE_SHORT_CYC); // RULE8

   // Queue depth of up to 15 keeps events arriving mid-pulse from being lost
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_q <= 4'h0;
      end else if (clk_en_in) begin
         pend_q <= pend_q + {3'h0, pend_inc} - {3'h0, pulse_start}; // RULE18
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= sdir_pkg::SDIR_IDLE;
         cnt_q <= 16'h0000;
         len_q <= 16'h0001;
         int_n_q <= 1'b1;
      end else if (clk_en_in) begin
         case (state_q)
            sdir_pkg::SDIR_IDLE: begin
               if (pulse_start) begin
                  state_q <= sdir_pkg::SDIR_PULSE;
                  cnt_q <= 16'h0000;
                  len_q <= len_sel;
                  int_n_q <= 1'b0; // RULE7
               end
            end
            sdir_pkg::SDIR_PULSE: begin
               cnt_q <= cnt_q + 16'h0001;
               if (pulse_last) begin
                  state_q <= sdir_pkg::SDIR_IDLE;
                  int_n_q <= 1'b1;
               end
            end
            default: begin
               state_q <= sdir_pkg::SDIR_IDLE;
               int_n_q <= 1'b1;
            end
         endcase
      end
   end

   assign interrupt_out_n = int_n_q;

   // ****************************************
   // Checks
   // ****************************************
   logic [15:0] low_cnt_q;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         low_cnt_q <= 16'h0000;
      end else if (clk_en_in) begin
         low_cnt_q <= int_n_q ? 16'h0000 : low_cnt_q + 16'h0001;
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!resetn_in);

   a_rst_cnt_range: assert property (rst_err_q <= `SDIR_RST_ERR_MAX) // RULE2
      else $error("reset error counter beyond six");
   a_diag_read_clear: assert property (clk_en_in && cmd_rd_diag && fail_evt_in == '0
      |=> fail_q.io45 == 1'b0 && fail_q.io23 == 1'b0 && fail_q.io01 == 1'b0) // RULE3 RULE4 RULE6
      else $error("diagnostic read did not clear flags");
   a_io1_sticky: assert property (fail_q.io1 |=> fail_q.io1) // RULE5
      else $error("monitor failure flag cleared without reset");
   a_pulse_length: assert property ($rose(int_n_q) |-> low_cnt_q == len_q) // RULE7 RULE8
      else $error("interrupt pulse has wrong length");
   a_event_pulse: assert property (clk_en_in && pulse_req && pend_q == 4'h0
      && state_q == sdir_pkg::SDIR_IDLE ##1 clk_en_in |=> !int_n_q) // RULE7 RULE18
      else $error("event did not start a pulse");
   a_mask_all: assert property (clk_en_in && mask_q == 8'hff && !cmd_int_req
      && pend_q == 4'h0 |=> pend_q == 4'h0) // RULE9
      else $error("masked source queued a pulse");
   a_init_lock: assert property (clk_en_in && !init_q |=> $stable(mask_q) && $stable(behav_q)) // RULE8
      else $error("settings changed outside initialisation");
   a_io_change: assert property (clk_en_in && io_chg != 6'h00 |=> stat_a_q[5:0] != 6'h00) // RULE10
      else $error("input change not latched");
   a_wake_latch: assert property (clk_en_in && io_wake_in != 6'h00 && !cmd_rd_a
      |=> stat_a_q[11:6] != 6'h00) // RULE11
      else $error("wake event not latched");
   a_reg_events: assert property (clk_en_in && reg_evt_in.ilim_off |=> stat_a_q[15]) // RULE13
      else $error("regulator event not latched");
   a_bad_access: assert property (clk_en_in && (spi_clk_evt || spi_req_evt)
      |=> stat_b_q[1:0] != 2'h0) // RULE15 RULE16
      else $error("invalid access not flagged");
   a_int_request: assert property (clk_en_in && cmd_int_req |=> stat_b_q[2]) // RULE17
      else $error("interrupt request not latched");

   c_diag_read: cover property (cmd_rd_diag && fail_q != '0);
   c_pulse_done: cover property ($rose(int_n_q));
   c_queued: cover property (state_q == sdir_pkg::SDIR_PULSE && pend_q != 4'h0);
   c_clk_error: cover property (spi_clk_evt);

endmodule // sdir_report

`default_nettype wire

// ### sdir_report_tb.sv
/*
 * Self-checking bench for the diagnostic report and interrupt block.
 * Assumes the host model file is compiled first and a 200 MHz clock.
 */
`timescale 1ns/100ps
`include "sdir_cfg.svh"
`default_nettype none

module sdir_report_tb;
   logic clock_in = 1'b0;
   logic resetn_in, clk_en_in, inc, dec, bb, en_nxt;
   logic busy = 1'b0;
   logic [7:0] gf;
   logic [3:0] fail_evt, reg_evt;
   logic [5:0] io_level, io_wake;
   wire logic lclk, sel_n, mosi, miso, miso_oe, irq_n, init_ph, done;
   wire logic [15:0] reply;
   int num_errors = 0, checks = 0, seed = 37826, low_cyc = 0, k;
   logic [16:0] rq[$];
   logic [16:0] nxt;
   int pq[$];

   always #2.5 clock_in = ~clock_in;

   sdir_report #(.PULSE_SHORT_CYC(8), .PULSE_LONG_CYC(20)) DUT (
      .clock_in(clock_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
      .link_clk_in(lclk), .serial_select_n_in(sel_n), .mosi_in(mosi),
      .miso_out(miso), .miso_oe_out(miso_oe), .global_flags_in(gf),
      .fail_evt_in(fail_evt), .rst_err_inc_in(inc), .rst_err_dec_in(dec),
      .io_level_in(io_level), .io_wake_in(io_wake), .reg_evt_in(reg_evt),
      .buck_boost_state_in(bb), .interrupt_out_n(irq_n), .init_phase_out(init_ph));

   sdir_host_model host (
      .link_clk_out(lclk), .serial_select_n_out(sel_n), .mosi_out(mosi),
      .miso_in(miso), .miso_oe_in(miso_oe), .reply_out(reply), .done_out(done));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic test_done;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Reply of frame N belongs to the command of the last sixteen-clock frame before it
   always @(posedge done) begin
      if (rq.size() == 0) chk("reply queue", 16'h0001, 16'h0000);
      else if (rq[0][16]) chk("reply", rq[0][15:0], reply);
      if (rq.size() != 0) void'(rq.pop_front());
   end

   // Random stalls; pulse width counts enabled edges only, event strobes never stall
   always @(negedge clock_in) begin
      en_nxt = busy | (($random(seed) & 15) != 0);
      if (irq_n === 1'b0) begin
         if (en_nxt) low_cyc++;
         if (low_cyc > 100) begin
            chk("pulse bound", 16'h0064, 16'(low_cyc));
            test_done();
         end
      end else if (low_cyc != 0) begin
         chk("pulse length", 16'(pq.size() ? pq.pop_front() : 0), 16'(low_cyc));
         low_cyc = 0;
      end
      clk_en_in = en_nxt;
   end

   initial begin
      repeat (50000) @(posedge clock_in);
      chk("run bound", 16'h0000, 16'h0001);
      test_done();
   end

   // ****************************************
   // Stimulus helpers
   // ****************************************
   function automatic logic [16:0] dg(input logic [2:0] c, input logic [3:0] f);
      return {1'b1, gf, c, 1'b0, f};
   endfunction

   // Bad-count frames leave the expected snapshot alone
   task automatic cmd(input logic [15:0] w, input int n, input logic [16:0] e);
      rq.push_back(n == 16 ? nxt : 17'h00000);
      if (n == 16) nxt = e;
      host.frame(w, n);
      @(negedge clock_in);
      gf = 8'($random(seed));
      bb = 1'($random(seed));
   endtask

   // Source k: 0-5 level change, 6-11 wake, 12-15 regulator, 16-19 fail
   task automatic src(input int s);
      @(negedge clock_in);
      busy = 1'b1;
      @(negedge clock_in);
      if (s < 6) io_level[s] = ~io_level[s];
      else {fail_evt, reg_evt, io_wake} = 14'h0001 << (s - 6);
      @(negedge clock_in);
      {fail_evt, reg_evt, io_wake} = 14'h0000;
      busy = 1'b0;
   endtask

   task automatic step(input logic i, input logic d, input int n);
      @(negedge clock_in);
      busy = 1'b1;
      repeat (n) begin
         @(negedge clock_in);
         {inc, dec} = {i, d};
         @(negedge clock_in);
         {inc, dec} = 2'b00;
      end
      busy = 1'b0;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {resetn_in, inc, dec} = 3'h0;
      bb = 1'($random(seed));
      {fail_evt, reg_evt, io_level, io_wake} = 20'h00000;
      gf = 8'($random(seed));
      repeat (6) @(negedge clock_in);
      chk("reset state", 16'h0006, {13'h0, irq_n, init_ph, miso_oe});
      repeat (2) @(negedge clock_in);
      resetn_in = 1'b1;
      repeat (8) @(negedge clock_in);
      nxt = {1'b1, 16'h0000};
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h1, 4'h0));
      for (k = 16; k < 20; k++) src(k);
      repeat (10) @(negedge clock_in);
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h1, 4'hf));
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h1, 4'h2));
      step(1'b1, 1'b0, 7);
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h6, 4'h2));
      step(1'b1, 1'b1, 3);
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h6, 4'h2));
      step(1'b0, 1'b1, 7);
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h0, 4'h2));
      for (k = 0; k < 16; k++) begin
         pq.push_back(8);
         src(k);
         repeat (30) @(negedge clock_in);
         cmd(`SDIR_CMD_READ_INTA, 16, {1'b1, 16'h0001 << k});
      end
      cmd({`SDIR_OP_WR_MASK, 8'hff}, 16, 17'h00000);
      k = $unsigned($random(seed)) % 16;
      src(k);
      repeat (30) @(negedge clock_in);
      cmd(`SDIR_CMD_READ_INTA, 16, {1'b1, 16'h0001 << k});
      cmd({`SDIR_OP_WR_MASK, 8'h00}, 16, 17'h00000);
      cmd({`SDIR_OP_WR_BEHAV, 8'h01}, 16, 17'h00000);
      pq.push_back(20);
      src(12);
      repeat (40) @(negedge clock_in);
      cmd(`SDIR_CMD_READ_INTA, 16, {1'b1, 16'h1000});
      cmd({`SDIR_OP_WR_BEHAV, 8'h02}, 16, 17'h00000);
      src(13);
      repeat (40) @(negedge clock_in);
      cmd(`SDIR_CMD_READ_INTA, 16, {1'b1, 16'h2000});
      cmd({`SDIR_OP_WR_BEHAV, 8'h00}, 16, 17'h00000);
      pq.push_back(8);
      pq.push_back(8);
      src(6);
      src(7);
      repeat (60) @(negedge clock_in);
      cmd(`SDIR_CMD_READ_INTA, 16, {1'b1, 16'h00c0});
      cmd(`SDIR_CMD_INIT_DONE, 16, 17'h00000);
      chk("init phase end", 16'h0000, {15'h0, init_ph});
      pq.push_back(8);
      cmd({`SDIR_OP_WR_BEHAV, 8'h01}, 16, 17'h00000);
      pq.push_back(8);
      src(14);
      repeat (40) @(negedge clock_in);
      cmd(`SDIR_CMD_READ_DIAG, 16, dg(3'h0, 4'h2));
      pq.push_back(8);
      cmd(`SDIR_CMD_READ_DIAG, 17, 17'h00000);
      cmd(`SDIR_CMD_READ_DIAG, 15, 17'h00000);
      cmd(`SDIR_CMD_READ_INTERRUPT_OUT_N, 16, {1'b1, bb, 15'h0003});
      pq.push_back(8);
      cmd(`SDIR_CMD_INT_REQ, 16, 17'h00000);
      cmd(`SDIR_CMD_READ_INTERRUPT_OUT_N, 16, {1'b1, bb, 15'h0004});
      pq.push_back(8);
      cmd(16'h1234, 16, {1'b1, gf, 8'h00});
      cmd(`SDIR_CMD_READ_INTERRUPT_OUT_N, 16, {1'b1, bb, 15'h0002});
      cmd(`SDIR_CMD_READ_DIAG, 16, 17'h00000);
      repeat (20) @(negedge clock_in);
      chk("pulses left", 16'h0000, 16'(pq.size()));
      test_done();
   end
endmodule // sdir_report_tb

`default_nettype wire
